// *** spv_port.sv ***
/*
 Device end of the two-wire serial program/verify port: mode entry, framing,
 command execution, pointer, table latch and self-timed bulk erase.
 Assumes pins arrive asynchronously and the array answers reads one cycle later.
*/
`timescale 1ns/10ps
module spv_port #(
    parameter int ERASE_CYCLES = spv_pkg::ERASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic prog_clock_pin_i,
    input wire logic prog_data_pin_i,
    input wire logic master_clear_prog_voltage_pin_i,
    input wire logic elevated_prog_voltage_i,
    input wire logic low_volt_select_pin_i,
    input wire logic low_volt_enable_bit_i,
    input wire logic [7:0] nvm_rdata_i,
    output logic prog_data_pin_o,
    output logic prog_data_pin_oe_o,
    output logic prog_mode_o,
    output logic io_hiz_o,
    output logic shared_select_io_en_o,
    output spv_pkg::spv_nvm_req_type nvm_req_o,
    output spv_pkg::spv_core_instr_type core_instr_o,
    output spv_pkg::spv_erase_type erase_o,
    output logic prog_start_o,
    output logic [21:0] pointer_o,
    output logic [7:0] table_latch_o
);
    localparam int ECW = $clog2(ERASE_CYCLES + 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic [1:0] n, input logic dn);
        ptr_step = dn ? p - 22'(n) : p + 22'(n);
    endfunction

    function automatic logic [9:0] erase_mask(input logic [7:0] opt);
        if (opt == spv_pkg::ERASE_CHIP) begin
            erase_mask = spv_pkg::MASK_ALL;
        end else if (opt == spv_pkg::ERASE_EEPROM) begin
            erase_mask = spv_pkg::MASK_EEPROM;
        end else if (opt == spv_pkg::ERASE_BOOT) begin
            erase_mask = spv_pkg::MASK_BOOT;
        end else if (opt[7:3] == spv_pkg::ERASE_BLK_HI) begin
            erase_mask = spv_pkg::MASK_BLK1 << opt[2:0];
        end else begin
            erase_mask = spv_pkg::MASK_NONE;
        end
    endfunction

    function automatic logic is_out_cmd(input logic [3:0] c);
        is_out_cmd = (c == spv_pkg::CMD_SHIFT_LATCH) || (c[3:2] == spv_pkg::GRP_TRD);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_s;
    logic [4:0] pins_p;

    spv_sync #(.WIDTH(5)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i({low_volt_select_pin_i, elevated_prog_voltage_i, master_clear_prog_voltage_pin_i,
              prog_data_pin_i, prog_clock_pin_i}),
        .q_o(pins_s),
        .q_prev_o(pins_p)
    );

    spv_pkg::spv_mode_type mode_r;
    logic in_mode;
    logic rise;
    logic fall;
    logic clr_rise;
    logic [4:0] cnt_r;
    logic [18:0] sh_r;
    logic [3:0] cmd_r;
    logic [3:0] cmd_now;
    logic [15:0] operand;
    logic cmd_done;
    logic frame_done;
    logic cmd_ok_r;
    logic exec_cmd;
    logic exec_frame;
    logic busy_r;
    logic [ECW-1:0] ecnt_r;
    logic pend_r;
    logic [7:0] opt_r;
    logic [9:0] clear_r;
    logic out_r;
    logic dout_r;
    logic oe_r;
    logic [21:0] ptr_r;
    logic [7:0] w_r;
    logic [7:0] latch_r;
    logic rd_wait_r;
    spv_pkg::spv_nvm_req_type nvm_r;
    spv_pkg::spv_core_instr_type core_r;
    logic prog_r;

    assign in_mode = (mode_r != spv_pkg::MODE_OFF);
    assign rise = ce_i & in_mode & pins_s[0] & ~pins_p[0];
    assign fall = ce_i & in_mode & ~pins_s[0] & pins_p[0];
    assign clr_rise = ce_i & pins_s[2] & ~pins_p[2];

    // ----------------------------------------------------------------
    // Mode entry
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= spv_pkg::MODE_OFF;
        end else if (ce_i) begin
            if (!pins_s[2]) begin
                mode_r <= spv_pkg::MODE_OFF;
            end else if (clr_rise && !pins_s[0] && !pins_s[1] && !in_mode) begin
                if (pins_s[3]) begin
                    mode_r <= spv_pkg::MODE_HV;
                end else if (low_volt_enable_bit_i && pins_s[4]) begin
                    mode_r <= spv_pkg::MODE_LV;
                end
            end
        end
    end

    assign prog_mode_o = in_mode;
    assign io_hiz_o = in_mode;
    assign shared_select_io_en_o = (mode_r != spv_pkg::MODE_LV);

    // ----------------------------------------------------------------
    // Framing
    // ----------------------------------------------------------------
    assign cmd_done = fall && (cnt_r == 5'(spv_pkg::CMD_BITS - 1));
    assign frame_done = fall && (cnt_r == 5'(spv_pkg::FRAME_BITS - 1));
    assign cmd_now = {pins_s[1], sh_r[2:0]};
    assign operand = {pins_s[1], sh_r[18:4]};
    assign exec_cmd = cmd_done && !busy_r;
    assign exec_frame = frame_done && cmd_ok_r && !busy_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
            sh_r <= '0;
        end else if (ce_i) begin
            if (!in_mode) begin
                cnt_r <= '0;
            end else if (fall) begin
                sh_r[cnt_r] <= pins_s[1];
                cnt_r <= frame_done ? 5'h00 : cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_r <= spv_pkg::CMD_CORE;
            cmd_ok_r <= 1'b0;
        end else if (ce_i && cmd_done) begin
            cmd_r <= cmd_now;
            cmd_ok_r <= !busy_r;
        end
    end

    // ----------------------------------------------------------------
    // Serial data output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_r <= 1'b0;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (ce_i) begin
            if (!in_mode || frame_done) begin
                out_r <= 1'b0;
                oe_r <= 1'b0;
            end else if (exec_cmd) begin
                out_r <= is_out_cmd(cmd_now);
            end else if (rise && out_r && cnt_r >= 5'(spv_pkg::OUT_START)) begin
                dout_r <= latch_r[3'(cnt_r - 5'(spv_pkg::OUT_START))];
                oe_r <= 1'b1;
            end
        end
    end

    assign prog_data_pin_o = dout_r;
    assign prog_data_pin_oe_o = oe_r;

    // ----------------------------------------------------------------
    // Pointer and core instruction
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_r <= spv_pkg::PTR_RST;
            w_r <= spv_pkg::LATCH_RST;
            core_r <= '0;
        end else if (ce_i) begin
            core_r.valid <= 1'b0;
            if (exec_cmd && cmd_now[3:2] == spv_pkg::GRP_TRD && cmd_now != spv_pkg::CMD_TRD) begin
                ptr_r <= ptr_step(ptr_r, 2'd1, cmd_now == spv_pkg::CMD_TRD_POST_DEC);
            end else if (exec_frame && cmd_r == spv_pkg::CMD_TWR_INC2) begin
                ptr_r <= ptr_step(ptr_r, 2'd2, 1'b0);
            end else if (exec_frame && cmd_r == spv_pkg::CMD_TWR_DEC2) begin
                ptr_r <= ptr_step(ptr_r, 2'd2, 1'b1);
            end else if (exec_frame && cmd_r == spv_pkg::CMD_CORE) begin
                core_r.valid <= 1'b1;
                core_r.instr <= operand;
                if (operand[15:8] == spv_pkg::OPC_LOAD_LIT) begin
                    w_r <= operand[7:0];
                end else if (operand[15:8] == spv_pkg::OPC_STORE_REG) begin
                    if (operand[7:0] == spv_pkg::REG_PTR_UPPER) begin
                        ptr_r[21:16] <= w_r[5:0];
                    end else if (operand[7:0] == spv_pkg::REG_PTR_HIGH) begin
                        ptr_r[15:8] <= w_r;
                    end else if (operand[7:0] == spv_pkg::REG_PTR_LOW) begin
                        ptr_r[7:0] <= w_r;
                    end
                end
            end
        end
    end

    assign pointer_o = ptr_r;
    assign core_instr_o = core_r;

    // ----------------------------------------------------------------
    // Array access and table latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nvm_r <= '0;
            prog_r <= 1'b0;
        end else if (ce_i) begin
            nvm_r.re <= 1'b0;
            nvm_r.we <= 1'b0;
            prog_r <= 1'b0;
            if (exec_cmd && cmd_now[3:2] == spv_pkg::GRP_TRD) begin
                nvm_r.re <= 1'b1;
                nvm_r.addr <= ptr_step(ptr_r, 2'(cmd_now == spv_pkg::CMD_TRD_PRE_INC), 1'b0);
            end else if (exec_frame && cmd_r[3:2] == spv_pkg::GRP_TWR) begin
                nvm_r.we <= 1'b1;
                nvm_r.addr <= ptr_r;
                nvm_r.wdata <= operand[7:0];
                prog_r <= (cmd_r == spv_pkg::CMD_TWR_PROG);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_wait_r <= 1'b0;
            latch_r <= spv_pkg::LATCH_RST;
        end else if (ce_i) begin
            rd_wait_r <= nvm_r.re;
            if (rd_wait_r) begin
                latch_r <= nvm_rdata_i;
            end
        end
    end

    assign nvm_req_o = nvm_r;
    assign prog_start_o = prog_r;
    assign table_latch_o = latch_r;

    // ----------------------------------------------------------------
    // Bulk erase
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_r <= 1'b0;
            opt_r <= spv_pkg::LATCH_RST;
            busy_r <= 1'b0;
            ecnt_r <= '0;
            clear_r <= spv_pkg::MASK_NONE;
        end else if (ce_i) begin
            clear_r <= spv_pkg::MASK_NONE;
            if (!in_mode) begin
                pend_r <= 1'b0;
            end else if (exec_frame && cmd_r[3:2] == spv_pkg::GRP_TWR && ptr_r == spv_pkg::ERASE_OPT_ADDR) begin
                pend_r <= (erase_mask(operand[7:0]) != spv_pkg::MASK_NONE);
                opt_r <= operand[7:0];
            end else if (exec_cmd && cmd_now == spv_pkg::CMD_CORE && pend_r) begin
                pend_r <= 1'b0;
                busy_r <= 1'b1;
                ecnt_r <= ECW'(ERASE_CYCLES - 1);
            end
            if (busy_r) begin
                if (ecnt_r == '0) begin
                    busy_r <= 1'b0;
                    clear_r <= erase_mask(opt_r);
                end else begin
                    ecnt_r <= ecnt_r - 1'b1;
                end
            end
        end
    end

    assign erase_o = '{busy: busy_r, option: opt_r, clear_mask: clear_r};

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_lv_entry;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(mode_r == spv_pkg::MODE_LV) |-> $past(low_volt_enable_bit_i) && $past(pins_s[4]);
    endproperty
    a_lv_entry: assert property (p_lv_entry) else $error("low-voltage entry without enable");

    property p_sel_hiz;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(mode_r == spv_pkg::MODE_LV) |-> !shared_select_io_en_o && io_hiz_o && $past(!io_hiz_o);
    endproperty
    a_sel_hiz: assert property (p_sel_hiz) else $error("select pin or hiz wrong in mode");

    property p_drive_after_rise;
        @(posedge clk_i) disable iff (!rstn_i)
        ($changed(prog_data_pin_o) || $rose(prog_data_pin_oe_o)) |-> $past(rise);
    endproperty
    a_drive_after_rise: assert property (p_drive_after_rise) else $error("data changed off rising edge");

    property p_release;
        @(posedge clk_i) disable iff (!rstn_i)
        frame_done && ce_i |=> !prog_data_pin_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("data pin not released at frame end");

    property p_lsb_first;
        @(posedge clk_i) disable iff (!rstn_i)
        rise && out_r && !frame_done && cnt_r == 5'(spv_pkg::OUT_START) |=> prog_data_pin_o == $past(latch_r[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first output bit not latch bit 0");

    property p_inc2;
        @(posedge clk_i) disable iff (!rstn_i)
        exec_frame && ce_i && cmd_r == spv_pkg::CMD_TWR_INC2 |=> ptr_r == $past(ptr_r) + 22'h000002;
    endproperty
    a_inc2: assert property (p_inc2) else $error("pointer not advanced by two");

    property p_write_prog;
        @(posedge clk_i) disable iff (!rstn_i)
        exec_frame && ce_i && cmd_r == spv_pkg::CMD_TWR_PROG |=> nvm_req_o.we && prog_start_o
            && nvm_req_o.wdata == $past(operand[7:0]);
    endproperty
    a_write_prog: assert property (p_write_prog) else $error("write and program start missing");

    property p_core;
        @(posedge clk_i) disable iff (!rstn_i)
        exec_frame && ce_i && cmd_r == spv_pkg::CMD_CORE |=> core_instr_o.valid
            && core_instr_o.instr == $past(operand);
    endproperty
    a_core: assert property (p_core) else $error("core instruction not passed");

    property p_erase_start;
        @(posedge clk_i) disable iff (!rstn_i)
        exec_cmd && ce_i && cmd_now == spv_pkg::CMD_CORE && pend_r |=> erase_o.busy ##1 erase_o.busy;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase did not start on NOP");

    property p_erase_clear;
        @(posedge clk_i) disable iff (!rstn_i)
        $fell(busy_r) |-> erase_o.clear_mask == erase_mask(opt_r) && erase_o.clear_mask != spv_pkg::MASK_NONE;
    endproperty
    a_erase_clear: assert property (p_erase_clear) else $error("protect clear mask wrong");

    c_read: cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(prog_data_pin_oe_o));
    c_erase: cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(busy_r));
    c_prog: cover property (@(posedge clk_i) disable iff (!rstn_i) prog_start_o);
endmodule

// *** spv_pkg.sv ***
/*
 Shared constants and carrier types for the serial program/verify port.
 Assumes a 125 MHz system clock and a byte-wide nonvolatile array port outside.
*/
package spv_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int ERASE_TIME_US = 5000;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    localparam int CMD_BITS = 4;
    localparam int OPD_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + OPD_BITS;
    localparam int OUT_BITS = 8;
    localparam int OUT_START = FRAME_BITS - OUT_BITS;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
    localparam logic [3:0] CMD_TRD = 4'h8;
    localparam logic [3:0] CMD_TRD_POST_INC = 4'h9;
    localparam logic [3:0] CMD_TRD_POST_DEC = 4'ha;
    localparam logic [3:0] CMD_TRD_PRE_INC = 4'hb;
    localparam logic [3:0] CMD_TWR = 4'hc;
    localparam logic [3:0] CMD_TWR_INC2 = 4'hd;
    localparam logic [3:0] CMD_TWR_DEC2 = 4'he;
    localparam logic [3:0] CMD_TWR_PROG = 4'hf;
    localparam logic [1:0] GRP_TRD = 2'h2;
    localparam logic [1:0] GRP_TWR = 2'h3;

    // ----------------------------------------------------------------
    // Pointer, core decode and erase options
    // ----------------------------------------------------------------
    localparam int PTR_W = 22;
    localparam logic [21:0] PTR_RST = 22'h000000;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] OPC_LOAD_LIT = 8'h0e;
    localparam logic [7:0] OPC_STORE_REG = 8'h6e;
    localparam logic [7:0] REG_PTR_UPPER = 8'hf8;
    localparam logic [7:0] REG_PTR_HIGH = 8'hf7;
    localparam logic [7:0] REG_PTR_LOW = 8'hf6;
    localparam logic [21:0] ERASE_OPT_ADDR = 22'h3c0004;
    localparam logic [7:0] ERASE_CHIP = 8'h80;
    localparam logic [7:0] ERASE_EEPROM = 8'h81;
    localparam logic [7:0] ERASE_BOOT = 8'h83;
    localparam logic [4:0] ERASE_BLK_HI = 5'h11;
    localparam logic [9:0] MASK_ALL = 10'h3ff;
    localparam logic [9:0] MASK_EEPROM = 10'h001;
    localparam logic [9:0] MASK_BOOT = 10'h002;
    localparam logic [9:0] MASK_BLK1 = 10'h004;
    localparam logic [9:0] MASK_NONE = 10'h000;

    typedef enum logic [1:0] {MODE_OFF, MODE_HV, MODE_LV} spv_mode_type;

    typedef struct packed {
        logic re;
        logic we;
        logic [21:0] addr;
        logic [7:0] wdata;
    } spv_nvm_req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] instr;
    } spv_core_instr_type;

    typedef struct packed {
        logic busy;
        logic [7:0] option;
        logic [9:0] clear_mask;
    } spv_erase_type;

endpackage

// *** spv_sync.sv ***
/*
 Two-flop synchroniser bank with a third stage for edge detection.
 Assumes asynchronous inputs; q_prev_o is q_o delayed one enabled cycle.
*/
`timescale 1ns/10ps
module spv_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o,
    output logic [WIDTH-1:0] q_prev_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] prev_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= '0;
            q_r <= '0;
            prev_r <= '0;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_r <= meta_r;
            prev_r <= q_r;
        end
    end

    assign q_o = q_r;
    assign q_prev_o = prev_r;
endmodule

// *** spv_prog_model.sv ***
/*
 Programmer model for the serial program/verify port: mode entry and 20-bit frames.
 Assumes the bench resolves the data wire and feeds it back on line_i.
*/
`timescale 1ns/10ps
module spv_prog_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic pclk_o,
    output logic pdat_o,
    output logic poe_o,
    output logic mclr_o,
    output logic hv_o,
    output logic sel_o
);
    // ----------------------------------------------------------------
    // Entry, exit and bit transfer
    // ----------------------------------------------------------------
    initial {pclk_o, pdat_o, poe_o, mclr_o, hv_o, sel_o} = 6'h08;
    task automatic enter(input logic hv, input logic sel);
        @(posedge clk_i);
        {pclk_o, pdat_o, hv_o, sel_o} <= {2'b00, hv, sel};
        repeat (5) @(posedge clk_i);
        mclr_o <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic leave();
        @(posedge clk_i);
        {mclr_o, hv_o, sel_o} <= 3'h0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic xbit(input logic d, input logic drv, output logic s);
        @(posedge clk_i);
        {pclk_o, pdat_o, poe_o} <= {1'b1, d, drv};
        repeat (5) @(posedge clk_i);
        s = line_i;
        pclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic frame(input logic [3:0] cmd, input logic [15:0] opd, output logic [7:0] rd);
        logic [19:0] bits;
        logic s;
        logic outc;
        bits = {opd, cmd};
        outc = cmd == spv_pkg::CMD_SHIFT_LATCH || cmd[3:2] == spv_pkg::GRP_TRD;
        rd = 8'h00;
        for (int i = 0; i < 20; i++) begin
            xbit(bits[i], !(outc && i >= 12), s);
            if (i >= 12) rd[i-12] = s;
        end
    endtask
endmodule

// *** spv_port_tb_top.sv ***
/*
 Self-checking bench for spv_port: mode entry, table access, bulk erase.
 Assumes the programmer model drives the link; array reads answer one cycle late.
*/
`timescale 1ns/10ps
module spv_port_tb_top;
    // ----------------------------------------------------------------
    // Signals, recorders and tasks
    // ----------------------------------------------------------------
    localparam int ERASE_N = 300;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic lv_en = 1'b0;
    logic last_r = 1'b0;
    logic started = 1'b0;
    logic [7:0] rdata = 8'h00;
    logic [9:0] mask = 10'h000;
    logic pclk, pdat, poe, mclr, hv, sel, dev_d, dev_oe, wire_d, mode, hiz, sel_en, pstart;
    logic [21:0] ptr, wa;
    logic [7:0] wd, latch, rd;
    logic [15:0] ci;
    spv_pkg::spv_nvm_req_type req;
    spv_pkg::spv_core_instr_type core;
    spv_pkg::spv_erase_type er;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_wr = 0;
    int bcnt = 0;
    int nwr0;
    logic [7:0] eo [5] = '{8'h80, 8'h81, 8'h83, 8'h88, 8'h8f};
    logic [9:0] em [5] = '{10'h3ff, 10'h001, 10'h002, 10'h004, 10'h200};
    always #4 clk_i = ~clk_i;
    assign wire_d = dev_oe ? dev_d : (poe ? pdat : ~last_r);
    always @(posedge clk_i) begin
        if (dev_oe || poe) last_r <= wire_d;
        if (req.re) rdata <= req.addr[7:0] ^ 8'ha5;
        if (req.we) n_wr <= n_wr + 1;
        if (req.we) {wa, wd} <= {req.addr, req.wdata};
        if (core.valid) ci <= core.instr;
        if (er.busy) bcnt <= bcnt + 1;
        if (er.clear_mask != 10'h000) mask <= er.clear_mask;
        if (pstart) started <= 1'b1;
    end
    spv_port #(.ERASE_CYCLES(ERASE_N)) i_spv_port (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .prog_clock_pin_i(pclk), .prog_data_pin_i(wire_d),
        .master_clear_prog_voltage_pin_i(mclr), .elevated_prog_voltage_i(hv), .low_volt_select_pin_i(sel),
        .low_volt_enable_bit_i(lv_en), .nvm_rdata_i(rdata), .prog_data_pin_o(dev_d),
        .prog_data_pin_oe_o(dev_oe), .prog_mode_o(mode), .io_hiz_o(hiz), .shared_select_io_en_o(sel_en),
        .nvm_req_o(req), .core_instr_o(core), .erase_o(er), .prog_start_o(pstart), .pointer_o(ptr),
        .table_latch_o(latch));
    spv_prog_model i_spv_prog_model (
        .clk_i(clk_i), .line_i(wire_d), .pclk_o(pclk), .pdat_o(pdat), .poe_o(poe),
        .mclr_o(mclr), .hv_o(hv), .sel_o(sel));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xf(input logic [3:0] cmd, input logic [15:0] opd);
        i_spv_prog_model.frame(cmd, opd, rd);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic load_ptr(input logic [21:0] p);
        logic [7:0] b [3];
        b = '{{2'b00, p[21:16]}, p[15:8], p[7:0]};
        for (int k = 0; k < 3; k++) begin
            xf(4'h0, {8'h0e, b[k]});
            xf(4'h0, {8'h6e, 8'hf8 - 8'(k)});
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk("select_en", 1, sel_en);
        i_spv_prog_model.enter(1'b0, 1'b1);
        chk("mode", 0, mode);
        i_spv_prog_model.leave();
        lv_en <= 1'b1;
        i_spv_prog_model.enter(1'b0, 1'b1);
        chk("mode", 1, mode);
        chk("io_hiz", 1, hiz);
        chk("select_en", 0, sel_en);
        load_ptr(22'h000010);
        chk("pointer", 22'h000010, ptr);
        chk("core_instr", 16'h6ef6, ci);
        for (int k = 0; k < 5; k++) begin
            xf(k == 4 ? 4'h2 : 4'h8 + 4'(k), 16'h0000);
            chk("read_data", (k < 2 ? 8'h10 : 8'h11) ^ 8'ha5, rd);
            chk("table_latch", (k < 2 ? 8'h10 : 8'h11) ^ 8'ha5, latch);
            chk("pointer", 22'h000010 + 22'(5'b11010 >> k & 1), ptr);
            chk("data_oe", 0, dev_oe);
        end
        load_ptr(22'h000100);
        for (int k = 0; k < 4; k++) begin
            xf(4'hc + 4'(k), {8'h3c, 8'h40 + 8'(k)});
            chk("wr_addr", 22'h000100 + 22'(k == 2 ? 2 : 0), wa);
            chk("wr_data", 8'h40 + 8'(k), wd);
            chk("pointer", 22'h000100 + 22'(k == 1 ? 2 : 0), ptr);
            chk("writes", 32'(k + 1), n_wr);
        end
        chk("prog_start", 1, started);
        load_ptr(22'h3c0004);
        for (int k = 0; k < 5; k++) begin
            xf(4'hc, {8'h00, eo[k]});
            nwr0 = n_wr;
            bcnt = 0;
            mask = 10'h000;
            xf(4'h0, 16'h0000);
            xf(4'h0, 16'h0000);
            for (int t = 0; er.busy !== 1'b0; t++) begin
                if (t > 1000) begin
                    chk("erase_timeout", 0, 1);
                    finish_test();
                end
                @(posedge clk_i);
            end
            @(posedge clk_i);
            chk("erase_cycles", ERASE_N, bcnt);
            chk("clear_mask", em[k], mask);
            chk("writes", nwr0, n_wr);
            chk("core_instr", 16'h6ef6, ci);
            chk("erase_option", eo[k], er.option);
        end
        i_spv_prog_model.leave();
        chk("mode", 0, mode);
        chk("select_en", 1, sel_en);
        lv_en <= 1'b0;
        i_spv_prog_model.enter(1'b1, 1'b0);
        chk("mode", 1, mode);
        chk("select_en", 1, sel_en);
        xf(4'h8, 16'h0000);
        chk("read_data", 8'h04 ^ 8'ha5, rd);
        chk("data_oe", 0, dev_oe);
        finish_test();
    end
endmodule
